// *** verification/ics_fetch_model.sv ***
// opcode fetch model feeding the sequencer's first-byte handshake
// assumes the bench calls its tasks at the falling edge of clk
`timescale 1ns/1ps
`default_nettype none

module ics_fetch_model (
  // clock
  input wire logic clk,
  // handshake
  input wire logic ready,
  output logic valid,
  output logic [7:0] opcode
);
  // ==========================================================
  // request side
  initial begin
    valid = 1'b0;
    opcode = 8'h00;
  end

  // holds the byte until a take edge; ok low on timeout
  task automatic issue(input logic [7:0] op, output bit ok);
    int n;
    n = 0;
    valid = 1'b1;
    opcode = op;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    ok = (ready === 1'b1);
    @(posedge clk);
  endtask : issue

  // released bus shows the inverted last byte, not a stale copy
  task automatic stop();
    valid = 1'b0;
    opcode = ~opcode;
  endtask : stop
endmodule : ics_fetch_model

`default_nettype wire

// *** verification/ics_sequencer_tb.sv ***
// self-checking bench of the instruction cycle sequencer
// assumes the fetch model and design run on one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none

module ics_sequencer_tb;
  import ics_pkg::*;

  // ==========================================================
  // signals
  logic CLK, ARST_N, OPCODE_VALID, OPCODE_READY, WAIT_LOAD, IRQ_REQ, IRQ_ACK;
  logic LONG_SUBROUTINE_CALL, BUSY, INSTR_DONE, OPERAND_FETCH, EXTERNAL_DATA_MOVE, EXT_WAIT;
  logic [7:0] OPCODE;
  logic [2:0] WAIT_VALUE, EXTERNAL_WAIT_COUNT;
  ics_len_t INSTR_LEN;
  logic [4:0] INSTR_CYCLES, CYCLE_INDEX;
  int errors = 0;
  int samples_checked = 0;

  // opcode, bytes, cycles; bytes F means not checked
  localparam logic [15:0] TBL [50] = '{
    16'h2811, 16'h3911, 16'h9A11, 16'h5811, 16'h4811, 16'h6811,
    16'h2612, 16'h5712, 16'h2522, 16'h2422, 16'h5222, 16'h4222,
    16'h5333, 16'h4333, 16'h6333,
    16'hE411, 16'hF411, 16'hC411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
    16'h8533, 16'h9033, 16'h9314, 16'h8314,
    16'hC022, 16'hD022, 16'hD6F2,
    16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222, 16'h9222, 16'h7313,
    16'h1123, 16'h0123, 16'h8023, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'hD823,
    16'hB534, 16'hB434, 16'hB834, 16'hB634, 16'h1034,
    16'hA419
  };

  // ==========================================================
  // clock, design and fetch model
  initial CLK = 1'b0;
  always #10 CLK = ~CLK;

  ics_sequencer #(.CNT_W(5), .WAIT_W(3)) dut (
    .CLK(CLK), .ARST_N(ARST_N),
    .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE), .OPCODE_READY(OPCODE_READY),
    .WAIT_LOAD(WAIT_LOAD), .WAIT_VALUE(WAIT_VALUE), .EXTERNAL_WAIT_COUNT(EXTERNAL_WAIT_COUNT),
    .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK), .LONG_SUBROUTINE_CALL(LONG_SUBROUTINE_CALL),
    .BUSY(BUSY), .INSTR_DONE(INSTR_DONE), .INSTR_LEN(INSTR_LEN), .INSTR_CYCLES(INSTR_CYCLES),
    .CYCLE_INDEX(CYCLE_INDEX), .OPERAND_FETCH(OPERAND_FETCH),
    .EXTERNAL_DATA_MOVE(EXTERNAL_DATA_MOVE), .EXT_WAIT(EXT_WAIT)
  );

  ics_fetch_model fetch (.clk(CLK), .ready(OPCODE_READY), .valid(OPCODE_VALID), .opcode(OPCODE));

  // ==========================================================
  // checking helpers
  task automatic chk(input bit c, input string m);
    samples_checked++;
    if (!c) begin
      errors++;
      $display("[ERR] t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // one instruction, checked cycle by cycle; ends in its done cycle
  task automatic run_op(input logic [7:0] op, input logic [3:0] len, input logic [4:0] cyc,
      input logic ext, input logic [4:0] nw);
    bit ok;
    logic [4:0] k;
    fetch.issue(op, ok);
    chk(ok, "opcode not taken");
    if (!ok) begin
      tally_and_finish();
    end
    for (k = 5'h01; k <= cyc; k++) begin
      @(negedge CLK);
      chk(BUSY === 1'b1 && CYCLE_INDEX === k && INSTR_CYCLES === cyc, "cycle count");
      chk(len === 4'hF || (INSTR_LEN === len[1:0] &&
          OPERAND_FETCH === (k < {3'h0, len[1:0]})), "length or operand fetch");
      chk(INSTR_DONE === (k == cyc) && OPCODE_READY === (k == cyc), "done strobe");
      chk(EXTERNAL_DATA_MOVE === ext &&
          EXT_WAIT === (ext && k >= 5'h04 && k <= 5'h03 + nw), "external move");
      chk(IRQ_ACK === 1'b0 && LONG_SUBROUTINE_CALL === 1'b0, "spurious interrupt");
    end
  endtask : run_op

  // ==========================================================
  // scenarios
  task automatic sweep();
    logic [15:0] e;
    for (int i = 0; i < 50; i++) begin
      e = TBL[i];
      run_op(e[15:8], e[7:4], {1'b0, e[3:0]}, 1'b0, 5'h00); // to
    end
    fetch.stop();
    @(negedge CLK);
    chk(BUSY === 1'b0 && CYCLE_INDEX === 5'h00 && INSTR_LEN === LEN_NONE, "idle");
  endtask : sweep

  task automatic wait_scn();
    logic [7:0] ops [4] = '{8'hE0, 8'hE2, 8'hF0, 8'hF2};
    logic [2:0] nws [4] = '{3'h0, 3'h2, 3'h7, 3'h5};
    for (int i = 0; i < 4; i++) begin
      WAIT_LOAD = 1'b1;
      WAIT_VALUE = nws[i];
      @(negedge CLK);
      WAIT_LOAD = 1'b0;
      chk(EXTERNAL_WAIT_COUNT === nws[i], "wait register");
      run_op(ops[i], 4'h1, 5'h04 + {2'h0, nws[i]}, 1'b1, {2'h0, nws[i]});
      fetch.stop();
      @(negedge CLK);
    end
  endtask : wait_scn

  // reset in the middle of a long instruction, then the first take after release
  task automatic reset_scn();
    bit ok;
    fetch.issue(8'h84, ok);
    @(negedge CLK);
    fetch.stop();
    @(negedge CLK);
    chk(ok && BUSY === 1'b1 && CYCLE_INDEX === 5'h02 && INSTR_CYCLES === 5'h09,
        "long op before reset");
    ARST_N = 1'b0;
    @(negedge CLK);
    chk({BUSY, INSTR_DONE, OPCODE_READY, CYCLE_INDEX, INSTR_CYCLES,
        EXTERNAL_WAIT_COUNT} === '0, "mid-run reset");
    ARST_N = 1'b1;
    @(negedge CLK);
    chk(OPCODE_READY === 1'b1 && BUSY === 1'b0, "ready after reset");
    run_op(8'h00, 4'h1, 5'h01, 1'b0, 5'h00);
    fetch.stop();
    @(negedge CLK);
  endtask : reset_scn

  task automatic irq_scn();
    bit ok;
    fetch.issue(8'h85, ok);
    @(negedge CLK);
    IRQ_REQ = 1'b1;
    chk(ok && IRQ_ACK === 1'b0, "interrupt entry mid instruction");
    for (int k = 2; k <= 3; k++) begin
      @(negedge CLK);
      chk(IRQ_ACK === 1'b0 && INSTR_DONE === (k == 3), "interrupt entry early");
    end
    fetch.stop();
    @(negedge CLK);
    chk(IRQ_ACK === 1'b1 && LONG_SUBROUTINE_CALL === 1'b1, "interrupt entry");
    IRQ_REQ = 1'b0;
    chk(CYCLE_INDEX === 5'h01 && INSTR_LEN === LEN_NONE && INSTR_CYCLES === 5'h03 &&
        OPCODE_READY === 1'b0, "interrupt call start");
    for (int k = 2; k <= 3; k++) begin
      @(negedge CLK);
      chk(IRQ_ACK === 1'b0 && LONG_SUBROUTINE_CALL === 1'b1 && CYCLE_INDEX === k[4:0] &&
          INSTR_DONE === (k == 3), "interrupt call");
    end
    @(negedge CLK);
    chk(LONG_SUBROUTINE_CALL === 1'b0 && BUSY === 1'b0, "interrupt call end");
  endtask : irq_scn

  // ==========================================================
  // main sequence and hang guard
  initial begin
    ARST_N = 1'b0;
    WAIT_LOAD = 1'b0;
    WAIT_VALUE = 3'h0;
    IRQ_REQ = 1'b0;
    repeat (12) @(negedge CLK);
    chk({BUSY, INSTR_DONE, OPCODE_READY, IRQ_ACK, LONG_SUBROUTINE_CALL, INSTR_LEN,
        INSTR_CYCLES, CYCLE_INDEX, OPERAND_FETCH, EXTERNAL_DATA_MOVE, EXT_WAIT,
        EXTERNAL_WAIT_COUNT} === '0, "reset values");
    ARST_N = 1'b1;
    @(negedge CLK);
    sweep();
    wait_scn();
    reset_scn();
    irq_scn();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    $display("[ERR] t=%0t run limit reached", $time);
    tally_and_finish();
  end
endmodule : ics_sequencer_tb

`default_nettype wire

// *** verilog/ics_decoder.sv ***
// opcode to length and base duration lookup
// assumes a stable opcode; purely combinational
`timescale 1ns/1ps
`default_nettype none

module ics_decoder (
  // opcode in
  input wire logic [7:0] opcode,
  // timing out
  output ics_pkg::ics_len_t len,
  output ics_pkg::ics_cyc_t cycles,
  output logic ext
);
  import ics_pkg::*;

  logic [3:0] hi;
  ics_timing_t d;

  assign hi = opcode[7:4];
  assign len = d.len;
  assign cycles = d.cyc;
  assign ext = d.ext;

  // ==========================================================
  // lookup by low then high nibble
  always_comb begin
    d = ics_tm(LEN_ONE, CYC_ONE);
    if (opcode[3]) begin
      case (hi)
        4'h7, 4'h8, 4'hA: d = ics_tm(LEN_TWO, CYC_TWO);
        4'hB: d = ics_tm(LEN_THREE, CYC_FOUR);
        4'hD: d = ics_tm(LEN_TWO, CYC_THREE);
        default: d = ics_tm(LEN_ONE, CYC_ONE);
      endcase
    end else begin
      case (opcode[2:0])
        3'h6, 3'h7: begin
          case (hi)
            4'h7, 4'h8, 4'hA: d = ics_tm(LEN_TWO, CYC_TWO);
            4'hB: d = ics_tm(LEN_THREE, CYC_FOUR);
            default: d = ics_tm(LEN_ONE, CYC_TWO);
          endcase
        end
        3'h5: begin
          case (hi)
            4'h7, 4'h8: d = ics_tm(LEN_THREE, CYC_THREE);
            4'hA: d = ics_tm(LEN_ONE, CYC_ONE);
            4'hB, 4'hD: d = ics_tm(LEN_THREE, CYC_FOUR);
            default: d = ics_tm(LEN_TWO, CYC_TWO);
          endcase
        end
        3'h4: begin
          case (hi)
            4'h8, 4'hA: d = ics_tm(LEN_ONE, CYC_NINE);
            4'hB: d = ics_tm(LEN_THREE, CYC_FOUR);
            4'hD: d = ics_tm(LEN_ONE, CYC_TWO);
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: d = ics_tm(LEN_TWO, CYC_TWO);
            default: d = ics_tm(LEN_ONE, CYC_ONE);
          endcase
        end
        3'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: d = ics_tm(LEN_THREE, CYC_THREE);
            4'h7: d = ics_tm(LEN_ONE, CYC_THREE);
            4'h8, 4'h9: d = ics_tm(LEN_ONE, CYC_FOUR);
            4'hA: d = ics_tm(LEN_ONE, CYC_THREE);
            4'hE, 4'hF: d = EXT_MOVE_TIMING;
            default: d = ics_tm(LEN_ONE, CYC_ONE);
          endcase
        end
        3'h2: begin
          case (hi)
            4'h0, 4'h1: d = ics_tm(LEN_THREE, CYC_FOUR);
            4'h2, 4'h3: d = ics_tm(LEN_ONE, CYC_FOUR);
            4'h4, 4'h5, 4'h6: d = ics_tm(LEN_TWO, CYC_TWO);
            4'hE, 4'hF: d = EXT_MOVE_TIMING;
            default: d = ics_tm(LEN_TWO, CYC_TWO);
          endcase
        end
        3'h1: d = ics_tm(LEN_TWO, CYC_THREE);
        default: begin
          case (hi)
            4'h0: d = ics_tm(LEN_ONE, CYC_ONE);
            4'h1, 4'h2, 4'h3: d = ics_tm(LEN_THREE, CYC_FOUR);
            4'h9: d = ics_tm(LEN_THREE, CYC_THREE);
            4'hA, 4'hB: d = ics_tm(LEN_TWO, CYC_TWO);
            4'hC, 4'hD: d = ics_tm(LEN_TWO, CYC_TWO);
            4'hE, 4'hF: d = EXT_MOVE_TIMING;
            default: d = ics_tm(LEN_TWO, CYC_THREE);
          endcase
        end
      endcase
    end
  end

endmodule : ics_decoder

`default_nettype wire

// *** verilog/ics_pkg.sv ***
// shared types and constants of the instruction cycle sequencer
// assumes one counted cycle per core clock edge
`default_nettype none

package ics_pkg;

  // ==========================================================
  // types
  typedef logic [1:0] ics_len_t;
  typedef logic [3:0] ics_cyc_t;
  typedef enum logic {SQ_IDLE, SQ_RUN} ics_phase_t;

  typedef struct packed {
    ics_len_t len;
    ics_cyc_t cyc;
    logic ext;
  } ics_timing_t;

  // ==========================================================
  // instruction lengths in bytes
  localparam ics_len_t LEN_NONE = 2'h0;
  localparam ics_len_t LEN_ONE = 2'h1;
  localparam ics_len_t LEN_TWO = 2'h2;
  localparam ics_len_t LEN_THREE = 2'h3;

  // ==========================================================
  // durations in core clock cycles
  localparam ics_cyc_t CYC_ONE = 4'h1;
  localparam ics_cyc_t CYC_TWO = 4'h2;
  localparam ics_cyc_t CYC_THREE = 4'h3;
  localparam ics_cyc_t CYC_FOUR = 4'h4;
  localparam ics_cyc_t CYC_NINE = 4'h9;
  localparam ics_cyc_t CYC_EXT_BASE = CYC_FOUR;
  localparam ics_cyc_t CYC_IRQ_CALL = CYC_THREE;

  // ==========================================================
  // counter and register values
  localparam logic [3:0] WAIT_RESET = 4'h0;
  localparam logic [3:0] IDX_FIRST = 4'h1;
  localparam ics_timing_t EXT_MOVE_TIMING = '{len: LEN_ONE, cyc: CYC_EXT_BASE, ext: 1'b1};

  // ==========================================================
  // builds one timing entry without external wait states
  function automatic ics_timing_t ics_tm(input ics_len_t l, input ics_cyc_t c);
    ics_timing_t r;
    r.len = l;
    r.cyc = c;
    r.ext = 1'b0;
    return r;
  endfunction : ics_tm

endpackage : ics_pkg

`default_nettype wire

// *** verilog/ics_sequencer.sv ***
// instruction length and cycle sequencer between fetch and datapath
// assumes fetch, interrupt control and datapath all run on CLK
//
// What this block does
// - each counted cycle is one core clock
// - register alu ops: one byte, one cycle
// - indirect alu ops: one byte, two cycles
// - direct or immediate alu: two bytes, two
// - and/or into direct byte: two, two
// - immediate logic into direct: three, three
// - accumulator clear/complement/swap/rotate: one, one
// - direct to direct move: three, three
// - data pointer immediate load: three, three
// - code byte read: one byte, four cycles
// - external moves take four plus wait states
// - wait states come from a wait register
// - stack push and pop: two, two
// - nibble exchange takes two cycles
// - carry bit operations: two, two
// - indirect jump: one byte, three cycles
// - short jumps, calls, decrement jump: two, three
// - compare jumps: three bytes, four cycles
// - bit test jump clear: three, four
// - interrupt long call takes three cycles
`timescale 1ns/1ps
`default_nettype none

module ics_sequencer #(
  parameter int CNT_W = 5,
  parameter int WAIT_W = 3
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // opcode from fetch
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  output logic OPCODE_READY,
  // wait register
  input wire logic WAIT_LOAD,
  input wire logic [WAIT_W-1:0] WAIT_VALUE,
  output logic [WAIT_W-1:0] EXTERNAL_WAIT_COUNT,
  // interrupt entry
  input wire logic IRQ_REQ,
  output logic IRQ_ACK,
  output logic LONG_SUBROUTINE_CALL,
  // execution timing
  output logic BUSY,
  output logic INSTR_DONE,
  output ics_pkg::ics_len_t INSTR_LEN,
  output logic [CNT_W-1:0] INSTR_CYCLES,
  output logic [CNT_W-1:0] CYCLE_INDEX,
  output logic OPERAND_FETCH,
  output logic EXTERNAL_DATA_MOVE,
  output logic EXT_WAIT
);
  import ics_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    ics_phase_t phase;
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] total;
    ics_len_t len;
    logic ext;
    logic long_subroutine_call;
    logic done;
    logic ready;
    logic ack;
    logic fetch;
    logic wait_st;
    logic irq_hold;
    logic [WAIT_W-1:0] external_wait_count;
  } ics_state_t;

  ics_state_t q;
  ics_state_t next_q;
  ics_len_t dec_len;
  ics_cyc_t dec_cyc;
  logic dec_ext;
  logic boundary;
  logic take_irq;
  logic take_op;
  logic [CNT_W-1:0] run_total;

  // ==========================================================
  // opcode lookup
  ics_decoder u_decoder (
    .opcode(OPCODE),
    .len(dec_len),
    .cycles(dec_cyc),
    .ext(dec_ext)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    boundary = (q.phase == SQ_IDLE) || q.done;
    take_irq = boundary && q.irq_hold;
    take_op = boundary && !q.irq_hold && q.ready && OPCODE_VALID;
    run_total = CNT_W'(dec_cyc);
    if (dec_ext) begin
      run_total = CNT_W'(dec_cyc) + CNT_W'(q.external_wait_count);
    end
    next_q.ack = 1'b0;
    if (WAIT_LOAD) begin
      next_q.external_wait_count = WAIT_VALUE;
    end
    if (take_irq) begin
      next_q.phase = SQ_RUN;
      next_q.idx = CNT_W'(IDX_FIRST);
      next_q.total = CNT_W'(CYC_IRQ_CALL);
      next_q.len = LEN_NONE;
      next_q.ext = 1'b0;
      next_q.long_subroutine_call = 1'b1;
      next_q.ack = 1'b1;
    end else if (take_op) begin
      next_q.phase = SQ_RUN;
      next_q.idx = CNT_W'(IDX_FIRST);
      next_q.total = run_total;
      next_q.len = dec_len;
      next_q.ext = dec_ext;
      next_q.long_subroutine_call = 1'b0;
    end else if (q.phase == SQ_RUN && !q.done) begin
      next_q.idx = q.idx + 1'b1;
    end else if (q.phase == SQ_RUN) begin
      next_q.phase = SQ_IDLE;
      next_q.idx = '0;
      next_q.total = '0;
      next_q.len = LEN_NONE;
      next_q.ext = 1'b0;
      next_q.long_subroutine_call = 1'b0;
    end
    // last counted cycle of the running instruction
    next_q.done = (next_q.phase == SQ_RUN) && (next_q.idx == next_q.total);
    // a request seen during the call itself is the one being served
    next_q.irq_hold = IRQ_REQ && !next_q.long_subroutine_call;
    next_q.ready = ((next_q.phase == SQ_IDLE) || next_q.done) && !next_q.irq_hold;
    next_q.fetch = (next_q.phase == SQ_RUN) && (next_q.idx < CNT_W'(next_q.len));
    next_q.wait_st = next_q.ext && !next_q.done &&
                     (next_q.idx >= CNT_W'(CYC_EXT_BASE));
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
      q.external_wait_count <= WAIT_W'(WAIT_RESET);
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign OPCODE_READY = q.ready;
  assign EXTERNAL_WAIT_COUNT = q.external_wait_count;
  assign IRQ_ACK = q.ack;
  assign LONG_SUBROUTINE_CALL = q.long_subroutine_call;
  assign BUSY = (q.phase == SQ_RUN);
  assign INSTR_DONE = q.done;
  assign INSTR_LEN = q.len;
  assign INSTR_CYCLES = q.total;
  assign CYCLE_INDEX = q.idx;
  assign OPERAND_FETCH = q.fetch;
  assign EXTERNAL_DATA_MOVE = q.ext;
  assign EXT_WAIT = q.wait_st;

  // ==========================================================
  // checks
  a_index_step: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    BUSY && !INSTR_DONE |=> CYCLE_INDEX == $past(CYCLE_INDEX) + 1'b1
  ) else $error("cycle index did not step by one");

  a_alu_reg_one: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE[3] && OPCODE[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
    |=> INSTR_DONE && INSTR_LEN == LEN_ONE
  ) else $error("register alu op not one byte one cycle");

  a_alu_ind_two: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE[3:1] == 3'h3 && OPCODE[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
    |=> INSTR_LEN == LEN_ONE && !INSTR_DONE ##1 INSTR_DONE
  ) else $error("indirect alu op not two cycles");

  a_alu_dir_imm: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE[3:1] == 3'h2 && OPCODE[7:4] inside {4'h2, 4'h3, 4'h9}
    |=> INSTR_LEN == LEN_TWO && !INSTR_DONE ##1 INSTR_DONE
  ) else $error("direct or immediate alu op not two and two");

  a_logic_to_dir: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'h42, 8'h52, 8'h62}
    |=> INSTR_LEN == LEN_TWO && !INSTR_DONE ##1 INSTR_DONE
  ) else $error("logic into direct byte not two and two");

  a_imm_to_dir: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'h43, 8'h53, 8'h63}
    |=> INSTR_LEN == LEN_THREE && !INSTR_DONE ##1 !INSTR_DONE ##1 INSTR_DONE
  ) else $error("immediate into direct byte not three and three");

  a_acc_unary: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'hE4, 8'hF4, 8'hC4, 8'h03, 8'h13, 8'h23, 8'h33}
    |=> INSTR_DONE && INSTR_LEN == LEN_ONE
  ) else $error("accumulator unary op not one and one");

  a_three_moves: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'h85, 8'h90}
    |=> INSTR_LEN == LEN_THREE ##0 !INSTR_DONE [*2] ##1 INSTR_DONE
  ) else $error("three byte move not three cycles");

  a_code_read: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'h83, 8'h93}
    |=> !INSTR_DONE [*3] ##1 INSTR_DONE
  ) else $error("code byte read not four cycles");

  a_ext_length: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && dec_ext
    |=> EXTERNAL_DATA_MOVE &&
        INSTR_CYCLES == CNT_W'(CYC_EXT_BASE) + CNT_W'($past(EXTERNAL_WAIT_COUNT))
  ) else $error("external move length ignores wait states");

  a_ext_nowait: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && dec_ext && EXTERNAL_WAIT_COUNT == '0
    |=> !EXT_WAIT && !INSTR_DONE [*3] ##1 INSTR_DONE
  ) else $error("external move without waits not four cycles");

  a_wait_load: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    WAIT_LOAD |=> EXTERNAL_WAIT_COUNT == $past(WAIT_VALUE)
  ) else $error("wait register not loaded");

  a_stack_bits: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE inside {8'hC0, 8'hD0, 8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2, 8'h92}
    |=> INSTR_LEN == LEN_TWO && !INSTR_DONE ##1 INSTR_DONE
  ) else $error("stack or carry bit op not two and two");

  a_nibble_xchg: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE[7:1] == 7'h6B
    |=> !INSTR_DONE ##1 INSTR_DONE
  ) else $error("nibble exchange not two cycles");

  a_ind_jump: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && OPCODE == 8'h73
    |=> INSTR_LEN == LEN_ONE ##0 !INSTR_DONE [*2] ##1 INSTR_DONE
  ) else $error("indirect jump not three cycles");

  a_short_jump: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && (OPCODE[3:0] == 4'h1 || OPCODE[7:3] == 5'h1B ||
                OPCODE inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h80})
    |=> INSTR_LEN == LEN_TWO ##0 !INSTR_DONE [*2] ##1 INSTR_DONE
  ) else $error("short jump not two bytes three cycles");

  a_cmp_jump: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    take_op && ((OPCODE[7:4] == 4'hB && OPCODE[3:2] != 2'h0) || OPCODE == 8'h10)
    |=> INSTR_LEN == LEN_THREE ##0 !INSTR_DONE [*3] ##1 INSTR_DONE
  ) else $error("compare or bit test jump not three and four");

  a_irq_call: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    IRQ_ACK |-> LONG_SUBROUTINE_CALL && INSTR_CYCLES == CNT_W'(CYC_IRQ_CALL)
    ##2 INSTR_DONE && LONG_SUBROUTINE_CALL
  ) else $error("interrupt call not three cycles");

  a_irq_boundary: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    IRQ_ACK |-> $past(INSTR_DONE) || !$past(BUSY)
  ) else $error("interrupt entered inside an instruction");

  a_done_last: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    BUSY |-> INSTR_DONE == (CYCLE_INDEX == INSTR_CYCLES)
  ) else $error("done strobe not on last cycle");

  a_ready_edge: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    OPCODE_READY |-> !BUSY || INSTR_DONE
  ) else $error("opcode ready inside an instruction");

  a_operand_bytes: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    BUSY |-> OPERAND_FETCH == (CYCLE_INDEX < CNT_W'(INSTR_LEN))
  ) else $error("operand fetch does not match length");

  a_wait_window: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    EXT_WAIT |-> EXTERNAL_DATA_MOVE && !INSTR_DONE && CYCLE_INDEX >= CNT_W'(CYC_EXT_BASE)
  ) else $error("wait state outside an external move");

  a_irq_no_bytes: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    LONG_SUBROUTINE_CALL |-> INSTR_LEN == LEN_NONE && !OPERAND_FETCH && !EXTERNAL_DATA_MOVE
  ) else $error("interrupt call fetches operand bytes");

  a_idle_clear: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !BUSY |-> CYCLE_INDEX == '0 && !INSTR_DONE && !EXT_WAIT
  ) else $error("idle state not clear");

  c_back_to_back: cover property (
    @(posedge CLK) disable iff (!ARST_N)
    INSTR_DONE && CYCLE_INDEX == CNT_W'(IDX_FIRST) ##1 INSTR_DONE
  );

  c_ext_waits: cover property (
    @(posedge CLK) disable iff (!ARST_N)
    EXT_WAIT ##1 EXT_WAIT ##1 INSTR_DONE && EXTERNAL_DATA_MOVE
  );

  c_irq_after_op: cover property (
    @(posedge CLK) disable iff (!ARST_N)
    INSTR_DONE && !LONG_SUBROUTINE_CALL ##1 IRQ_ACK
  );

  c_long_op: cover property (
    @(posedge CLK) disable iff (!ARST_N)
    INSTR_DONE && INSTR_CYCLES == CNT_W'(CYC_NINE)
  );

endmodule : ics_sequencer

`default_nettype wire
